// *** inc/xtc_cfg.svh ***
// register offsets, reset values and fixed figures of the compensation datapath
`ifndef XTC_CFG_SVH
`define XTC_CFG_SVH

// register offsets on the byte register port
`define XTC_TURNOVER_OFS 8'h2c
`define XTC_HOT_COEF_OFS 8'h2d

// reset values
`define XTC_TURNOVER_RST 5'h00
`define XTC_HOT_COEF_RST 7'h00
`define XTC_TEMP_CODE_RST 10'h000

// turnover setting field: sign bit and whole field width (magnitude is bits 3:0)
`define XTC_TURNOVER_SIGN 4
`define XTC_TURNOVER_W 5

// 25.0 degrees in doubled kelvin (2 * 298)
`define XTC_TURNOVER_BASE 10'h254

// practical limits of the temperature code, 446 and 726 decimal
`define XTC_TEMP_MIN 10'h1be
`define XTC_TEMP_MAX 10'h2d6

// digital trim centre value, 16 decimal
`define XTC_DTRIM_CENTRE 6'h10

// curvature divide, 4096 = 2**12
`define XTC_CURVE_SHIFT 12

// temperature code field positions in the two readable bytes
`define XTC_CODE_LOW_MSB 7
`define XTC_CODE_HIGH_LSB 8

`endif

// *** inc/xtc_pkg.sv ***
// types shared by the compensation datapath
package xtc_pkg;

   // conversion pairing state for the two-sample average
   typedef enum logic [0:0] {
      XTC_WAIT_FIRST,
      XTC_WAIT_SECOND
   } xtc_pair_t;

   typedef logic [9:0] xtc_code_t;
   typedef logic signed [15:0] xtc_corr_t;

endpackage : xtc_pkg

// *** rtl/xtc_comp.sv ***
// crystal temperature compensation datapath: temperature code and net correction
//
// Behaviour
// - temperature code is a 10-bit value, twice absolute kelvin.
// - low byte holds code 7:0; high byte holds 9:8, upper bits zero.
// - reported code is the average of two consecutive conversions.
// - reported code is held within 446 to 726 decimal.
// - sensing and compensation update only while sense enable is set.
// - net correction is held as twice the total ppm correction.
// - net correction is offset correction plus curvature correction.
// - curvature term is coefficient times squared distance, divided by 4096.
// - cold coefficient below turnover, hot coefficient above it.
// - offset term is twice slope times analog trim minus digital trim less 16.
// - turnover setting counts half degrees up, or down when bit 4 set.
// - turnover resets to zero, takes preset at recall, software may overwrite.
// - hot coefficient is a 7-bit unsigned scaled curvature magnitude.
// - hot coefficient takes its preset at recall, software may overwrite.
`timescale 1ns/100ps
`include "xtc_cfg.svh"

module xtc_comp (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // byte register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   // control and power-up recall
   input wire logic tempSenseEnable,
   input wire logic presetLoad,
   input wire logic [4:0] presetTurnover,
   input wire logic [6:0] presetHotCurvature,
   // factory calibration values
   input wire logic [6:0] coldCurvatureCoefficient,
   input wire logic [4:0] factorySlopeSetting,
   input wire logic signed [5:0] analogTrimValue,
   input wire logic [5:0] digitalTrimValue,
   // converter samples from the sensor front end
   input wire logic adcValid,
   input wire logic [9:0] adcCode,
   // results
   output logic [7:0] temperatureCodeLow,
   output logic [7:0] temperatureCodeHigh,
   output logic signed [15:0] netCorrectionValue,
   output logic signed [13:0] initialOffsetCorrection,
   output logic [14:0] thermalCurvatureCorrection,
   output logic codeUpdated
);

   // register state
   logic [4:0] turnoverSetting;
   logic [6:0] hotCurvatureBits;
   xtc_pkg::xtc_code_t temperatureCodeBits;
   xtc_pkg::xtc_code_t firstSample;
   xtc_pkg::xtc_pair_t pairState;
   logic calcPending;

   // combinational terms
   logic [10:0] next_sampleSum;
   xtc_pkg::xtc_code_t next_average;
   xtc_pkg::xtc_code_t next_code;
   logic [9:0] turnoverReference;
   logic signed [11:0] tempDiff;
   logic [9:0] tempDist;
   logic [19:0] distSquared;
   logic [6:0] curvatureCoef;
   logic [26:0] curvatureProduct;
   logic [14:0] next_curvature;
   logic signed [11:0] slopeTrimProduct;
   logic signed [12:0] trimDifference;
   logic signed [13:0] next_offset;
   xtc_pkg::xtc_corr_t next_net;

   // register writes; recall preset wins over a software write in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         turnoverSetting <= `XTC_TURNOVER_RST;
         hotCurvatureBits <= `XTC_HOT_COEF_RST;
      end else if (presetLoad) begin
         turnoverSetting <= presetTurnover;
         hotCurvatureBits <= presetHotCurvature;
      end else if (regWrEn) begin
         if (regAddr == `XTC_TURNOVER_OFS) begin
            turnoverSetting <= regWrData[4:0];
         end
         if (regAddr == `XTC_HOT_COEF_OFS) begin
            hotCurvatureBits <= regWrData[6:0];
         end
      end
   end

   // register reads; unused and reserved bits read zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData <= 8'h00;
      end else if (regRdEn) begin
         case (regAddr)
            `XTC_TURNOVER_OFS: regRdData <= {3'h0, turnoverSetting};
            `XTC_HOT_COEF_OFS: regRdData <= {1'b0, hotCurvatureBits};
            default: regRdData <= 8'h00;
         endcase
      end
   end

   // two-sample average, clamped to the practical range
   always_comb begin
      next_sampleSum = {1'b0, firstSample} + {1'b0, adcCode};
      next_average = next_sampleSum[10:1];
      if (next_average < `XTC_TEMP_MIN) begin
         next_code = `XTC_TEMP_MIN;
      end else if (next_average > `XTC_TEMP_MAX) begin
         next_code = `XTC_TEMP_MAX;
      end else begin
         next_code = next_average;
      end
   end

   // conversion pairing; dropping sense enable discards a half-built pair
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pairState <= xtc_pkg::XTC_WAIT_FIRST;
         firstSample <= `XTC_TEMP_CODE_RST;
         temperatureCodeBits <= `XTC_TEMP_CODE_RST;
         calcPending <= 1'b0;
      end else if (!tempSenseEnable) begin
         pairState <= xtc_pkg::XTC_WAIT_FIRST;
         calcPending <= 1'b0;
      end else begin
         calcPending <= 1'b0;
         if (adcValid) begin
            case (pairState)
               xtc_pkg::XTC_WAIT_FIRST: begin
                  firstSample <= adcCode;
                  pairState <= xtc_pkg::XTC_WAIT_SECOND;
               end
               xtc_pkg::XTC_WAIT_SECOND: begin
                  temperatureCodeBits <= next_code;
                  calcPending <= 1'b1;
                  pairState <= xtc_pkg::XTC_WAIT_FIRST;
               end
               default: pairState <= xtc_pkg::XTC_WAIT_FIRST;
            endcase
         end
      end
   end

   // turnover reference in doubled kelvin, bit 4 steps downward
   always_comb begin
      if (turnoverSetting[`XTC_TURNOVER_SIGN]) begin
         turnoverReference = `XTC_TURNOVER_BASE - {6'h00, turnoverSetting[3:0]};
      end else begin
         turnoverReference = `XTC_TURNOVER_BASE + {6'h00, turnoverSetting[3:0]};
      end
   end

   // curvature term; the square is exact so only the final divide truncates
   always_comb begin
      tempDiff = $signed({2'b00, temperatureCodeBits}) - $signed({2'b00, turnoverReference});
      if (tempDiff < 0) begin
         tempDist = 10'(-tempDiff);
         curvatureCoef = coldCurvatureCoefficient;
      end else begin
         tempDist = tempDiff[9:0];
         curvatureCoef = hotCurvatureBits;
      end
      distSquared = tempDist * tempDist;
      curvatureProduct = {20'h00000, curvatureCoef} * {7'h00, distSquared};
      next_curvature = curvatureProduct[26:`XTC_CURVE_SHIFT];
   end

   // offset term from factory slope and trims, already doubled
   always_comb begin
      slopeTrimProduct = $signed({7'h00, factorySlopeSetting}) * 12'(analogTrimValue);
      trimDifference = 13'(slopeTrimProduct)
         - ($signed({7'h00, digitalTrimValue}) - $signed({7'h00, `XTC_DTRIM_CENTRE}));
      next_offset = {trimDifference, 1'b0};
      next_net = 16'(next_offset) + $signed({1'b0, next_curvature});
   end

   // results register one cycle after a new code, only while sensing runs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         initialOffsetCorrection <= 14'sh0000;
         thermalCurvatureCorrection <= 15'h0000;
         netCorrectionValue <= 16'sh0000;
         codeUpdated <= 1'b0;
      end else begin
         codeUpdated <= calcPending;
         if (calcPending && tempSenseEnable) begin
            initialOffsetCorrection <= next_offset;
            thermalCurvatureCorrection <= next_curvature;
            netCorrectionValue <= next_net;
         end
      end
   end

   // readable code bytes, high byte zero above bit 1
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         temperatureCodeLow <= 8'h00;
         temperatureCodeHigh <= 8'h00;
      end else begin
         temperatureCodeLow <= temperatureCodeBits[`XTC_CODE_LOW_MSB:0];
         temperatureCodeHigh <= {6'h00, temperatureCodeBits[9:`XTC_CODE_HIGH_LSB]};
      end
   end

endmodule : xtc_comp

// *** bench/xtc_comp_monitor.sv ***
// port checker for the compensation datapath
`timescale 1ns/100ps
module xtc_comp_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // watched inputs
   input wire logic [7:0] regAddr,
   input wire logic regRdEn,
   input wire logic tempSenseEnable,
   input wire logic adcValid,
   input wire logic [4:0] factorySlopeSetting,
   input wire logic signed [5:0] analogTrimValue,
   input wire logic [5:0] digitalTrimValue,
   // watched outputs
   input wire logic [7:0] regRdData,
   input wire logic [7:0] temperatureCodeLow,
   input wire logic [7:0] temperatureCodeHigh,
   input wire logic signed [15:0] netCorrectionValue,
   input wire logic signed [13:0] initialOffsetCorrection,
   input wire logic [14:0] thermalCurvatureCorrection,
   input wire logic codeUpdated
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic signed [13:0] offExp;
   logic [9:0] code;
   // trims are levels, so the live value stands for the one used at the pair
   assign offExp = 14'(2 * (int'(factorySlopeSetting) * int'(analogTrimValue)
      - (int'(digitalTrimValue) - 16)));
   assign code = {temperatureCodeHigh[1:0], temperatureCodeLow};
   sequence senseOff; !tempSenseEnable [*3]; endsequence
   sequence readAt(logic [7:0] a); regRdEn && regAddr == a; endsequence
   high_byte_zero_a: assert property (temperatureCodeHigh[7:2] == 6'h00)
      else $error("high byte upper bits set");
   code_range_a: assert property (codeUpdated |-> code >= 10'h1be && code <= 10'h2d6)
      else $error("code out of range");
   net_sum_a: assert property (codeUpdated |-> netCorrectionValue ==
      initialOffsetCorrection + $signed({1'b0, thermalCurvatureCorrection})) else $error("net sum");
   offset_trim_a: assert property (codeUpdated |-> initialOffsetCorrection == offExp)
      else $error("offset term wrong");
   pulse_once_a: assert property (codeUpdated |=> !codeUpdated)
      else $error("update pulse too long");
   pair_cause_a: assert property (codeUpdated |-> $past(adcValid && tempSenseEnable, 2))
      else $error("update without sample");
   sense_off_a: assert property (senseOff |=> !codeUpdated)
      else $error("update while sensing off");
   result_hold_a: assert property (!codeUpdated |-> $stable(code) && $stable(netCorrectionValue))
      else $error("result moved without update");
   turnover_read_a: assert property (readAt(8'h2c) |=> regRdData[7:5] == 3'h0)
      else $error("turnover reserved bits");
   hot_read_a: assert property (readAt(8'h2d) |=> !regRdData[7])
      else $error("hot coefficient bit 7 set");
endmodule : xtc_comp_monitor
bind xtc_comp xtc_comp_monitor i_xtc_comp_monitor (.clk, .arst_n, .regAddr, .regRdEn,
   .tempSenseEnable, .adcValid, .factorySlopeSetting, .analogTrimValue, .digitalTrimValue,
   .regRdData, .temperatureCodeLow, .temperatureCodeHigh, .netCorrectionValue,
   .initialOffsetCorrection, .thermalCurvatureCorrection, .codeUpdated);

// *** bench/xtc_comp_tb_top.sv ***
// self-checking bench for the compensation datapath
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("CHECK FAILED %0t mismatch", $time); end end
module xtc_comp_tb_top;
   logic clk, arst_n, regWrEn, regRdEn, tempSenseEnable, presetLoad, adcValid, codeUpdated;
   logic [7:0] regAddr, regWrData, regRdData, temperatureCodeLow, temperatureCodeHigh;
   logic [9:0] adcCode;
   logic [4:0] presetTurnover, factorySlopeSetting;
   logic [6:0] presetHotCurvature, coldCurvatureCoefficient;
   logic signed [5:0] analogTrimValue;
   logic [5:0] digitalTrimValue;
   logic signed [15:0] netCorrectionValue;
   logic signed [13:0] initialOffsetCorrection;
   logic [14:0] thermalCurvatureCorrection;
   int error_cnt = 0;
   int checks = 0;
   xtc_comp i_xtc_comp (.clk, .arst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
      .tempSenseEnable, .presetLoad, .presetTurnover, .presetHotCurvature,
      .coldCurvatureCoefficient, .factorySlopeSetting, .analogTrimValue, .digitalTrimValue,
      .adcValid, .adcCode, .temperatureCodeLow, .temperatureCodeHigh, .netCorrectionValue,
      .initialOffsetCorrection, .thermalCurvatureCorrection, .codeUpdated);
   // free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task final_report;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // inputs move 1 ns after the edge so the design never races the bench
   task step;
      @(posedge clk);
      #1;
   endtask : step
   task wr(input logic [7:0] a, input logic [7:0] d);
      step;
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      step;
      regWrEn = 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      step;
      regAddr = a;
      regRdEn = 1'b1;
      step;
      regRdEn = 1'b0;
      `CHK(regRdData, e)
   endtask : rd
   // one sample pair, then the expected code and corrections
   task pair(input int a, input int b, input logic [4:0] t, input logic [6:0] h);
      int c, t0, d, cv, off;
      c = (a + b) / 2;
      c = c < 446 ? 446 : (c > 726 ? 726 : c);
      t0 = t[4] ? 596 - int'(t[3:0]) : 596 + int'(t[3:0]);
      d = c - t0;
      cv = (int'(c < t0 ? coldCurvatureCoefficient : h) * d * d) >> 12;
      off = 2 * (int'(factorySlopeSetting) * int'(analogTrimValue) - (int'(digitalTrimValue) - 16));
      step;
      adcValid = 1'b1;
      adcCode = 10'(a);
      step;
      adcCode = 10'(b);
      step;
      adcValid = 1'b0;
      for (int i = 0; i < 8 && codeUpdated !== 1'b1; i++) step;
      if (codeUpdated !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED %0t no update pulse", $time);
         final_report;
      end
      `CHK({temperatureCodeHigh, temperatureCodeLow}, 16'(c))
      `CHK(int'({temperatureCodeHigh[1:0], temperatureCodeLow}) / 2 - 273, c / 2 - 273)
      `CHK(thermalCurvatureCorrection, 15'(cv))
      `CHK(netCorrectionValue, 16'(off + cv))
   endtask : pair
   task t_regs;
      rd(8'h2c, 8'h00);
      wr(8'h2c, 8'hff);
      rd(8'h2c, 8'h1f);
      wr(8'h2d, 8'hff);
      rd(8'h2d, 8'h7f);
      wr(8'h30, 8'hff);
      rd(8'h30, 8'h00);
      presetLoad = 1'b1;
      step;
      presetLoad = 1'b0;
      rd(8'h2c, 8'h05);
      rd(8'h2d, 8'h46);
      $display("done regs");
   endtask : t_regs
   task t_conv;
      logic [4:0] tv [3] = '{5'h10, 5'h1f, 5'h0f};
      tempSenseEnable = 1'b1;
      pair(700, 701, 5'h05, 7'h46);
      pair(300, 300, 5'h05, 7'h46);
      pair(900, 900, 5'h05, 7'h46);
      // turnover writes only while sensing is off
      foreach (tv[i]) begin
         tempSenseEnable = 1'b0;
         wr(8'h2c, {3'h0, tv[i]});
         tempSenseEnable = 1'b1;
         pair(600, 600, tv[i], 7'h46);
      end
      $display("done conv");
   endtask : t_conv
   task t_off;
      tempSenseEnable = 1'b0;
      adcCode = 10'h1f4;
      adcValid = 1'b1;
      repeat (2) step;
      adcValid = 1'b0;
      repeat (4) step;
      `CHK({temperatureCodeHigh, temperatureCodeLow}, 16'h0258)
      arst_n = 1'b0;
      step;
      `CHK(netCorrectionValue, 16'h0000)
      $display("done off");
   endtask : t_off
   // main sequence
   initial begin
      {arst_n, regWrEn, regRdEn, tempSenseEnable, presetLoad, adcValid} = '0;
      {regAddr, regWrData, adcCode} = '0;
      presetTurnover = 5'h05;
      presetHotCurvature = 7'h46;
      coldCurvatureCoefficient = 7'h20;
      factorySlopeSetting = 5'h03;
      analogTrimValue = 6'h3b;
      digitalTrimValue = 6'h14;
      repeat (3) step;
      arst_n = 1'b1;
      t_regs;
      t_conv;
      t_off;
      final_report;
   end
endmodule : xtc_comp_tb_top
